// [design/rhda_regs.sv]
// First root hub descriptor register with port power and overcurrent steering.
// Assumes a simple synchronous register port with one-cycle read and write strobes,
// power commands and overcurrent inputs already in the register clock domain.
`timescale 1ns/10ps
module rhda_regs #(
  parameter int UNIT_CYCLES = rhda_pkg::PGD_UNIT_CYCLES
) (
  // Clock and reset
  input  wire logic                                mclk_i,
  input  wire logic                                rst_i,
  // Register port
  input  wire logic [rhda_pkg::RHDA_ADDR_W-1:0]    reg_addr_i,
  input  wire logic                                reg_wr_i,
  input  wire logic                                reg_rd_i,
  input  wire logic [31:0]                         reg_wdata_i,
  output logic      [31:0]                         reg_rdata_o,
  output logic                                     reg_rvalid_o,
  // Port power control
  input  wire logic [rhda_pkg::RHDA_PORTS-1:0]     port_power_control_mask_i,
  input  wire rhda_pkg::rhda_power_cmd_s           power_cmd_i,
  output logic      [rhda_pkg::RHDA_PORTS-1:0]     port_power_o,
  output logic      [rhda_pkg::RHDA_PORTS-1:0]     port_power_good_o,
  // Overcurrent
  input  wire logic                                oc_global_i,
  input  wire logic [rhda_pkg::RHDA_PORTS-1:0]     oc_port_i,
  output logic      [rhda_pkg::RHDA_PORTS-1:0]     oc_report_o
);
  import rhda_pkg::*;

  rhda_fields_s          fields;
  rhda_fields_s          next_fields;
  logic [31:0]           next_rdata;
  logic                  next_rvalid;
  logic [RHDA_PORTS-1:0] next_power;
  logic [RHDA_PORTS-1:0] next_oc;
  logic                  hit;
  logic [31:0]           word;

  assign hit = (reg_addr_i == RHDA_OFFSET);

  // Read view; reserved bits read as their zero reset value
  always_comb begin
    word                   = RDATA_ZERO;
    word[PGD_MSB:PGD_LSB]  = fields.power_good_delay;
    word[NO_OVERCURRENT_PROTECTION_BIT]         = fields.no_overcurrent_protection;
    word[OVERCURRENT_REPORT_MODE_BIT]         = fields.overcurrent_report_mode;
    word[DT_BIT]           = DT_VALUE;
    word[NPS_BIT]          = fields.no_power_switching;
    word[PSM_BIT]          = fields.power_switch_mode;
    word[NDP_MSB:NDP_LSB]  = NDP_VALUE;
  end

  // Register write and read
  always_comb begin
    next_fields = fields;
    if (reg_wr_i && hit) begin
      // Bits 23-13 are not stored, so a careless write there cannot change anything
      next_fields.power_good_delay          = reg_wdata_i[PGD_MSB:PGD_LSB];
      next_fields.no_overcurrent_protection = reg_wdata_i[NO_OVERCURRENT_PROTECTION_BIT];
      next_fields.overcurrent_report_mode   = reg_wdata_i[OVERCURRENT_REPORT_MODE_BIT];
      next_fields.no_power_switching        = reg_wdata_i[NPS_BIT];
      next_fields.power_switch_mode         = reg_wdata_i[PSM_BIT];
    end
    next_rvalid = reg_rd_i;
    next_rdata  = (reg_rd_i && hit) ? word : RDATA_ZERO;
  end

  // Port power and overcurrent steering, one slice per port
  for (genvar i = 0; i < RHDA_PORTS; i++) begin : g_port
    always_comb begin
      next_power[i] = port_power_o[i];
      if (fields.no_power_switching) begin
        next_power[i] = 1'b1;
      end else if (fields.power_switch_mode && port_power_control_mask_i[i]) begin
        if (power_cmd_i.port_set[i]) begin
          next_power[i] = 1'b1;
        end else if (power_cmd_i.port_clear[i]) begin
          next_power[i] = 1'b0;
        end
      end else begin
        // Global switch mode and unmasked ports share the global commands
        if (power_cmd_i.global_set) begin
          next_power[i] = 1'b1;
        end else if (power_cmd_i.global_clear) begin
          next_power[i] = 1'b0;
        end
      end
      if (fields.no_overcurrent_protection) begin
        next_oc[i] = 1'b0;
      end else if (fields.overcurrent_report_mode) begin
        next_oc[i] = oc_port_i[i];
      end else begin
        next_oc[i] = oc_global_i;
      end
    end

    rhda_pg_timer #(
      .UNIT_CYCLES   (UNIT_CYCLES)
    ) u_pg_timer (
      .mclk_i        (mclk_i),
      .rst_i         (rst_i),
      .power_on_i    (port_power_o[i]),
      .delay_units_i (fields.power_good_delay),
      .good_o        (port_power_good_o[i])
    );
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      fields.power_good_delay          <= PGD_RESET;
      fields.no_overcurrent_protection <= NO_OVERCURRENT_PROTECTION_RESET;
      fields.overcurrent_report_mode   <= OVERCURRENT_REPORT_MODE_RESET;
      fields.no_power_switching        <= NPS_RESET;
      fields.power_switch_mode         <= PSM_RESET;
      reg_rdata_o                      <= RDATA_ZERO;
      reg_rvalid_o                     <= 1'b0;
      port_power_o                     <= '0;
      oc_report_o                      <= '0;
    end else begin
      fields       <= next_fields;
      reg_rdata_o  <= next_rdata;
      reg_rvalid_o <= next_rvalid;
      port_power_o <= next_power;
      oc_report_o  <= next_oc;
    end
  end

  // Checks; past_hit marks a mapped read in the previous cycle
  logic       past_hit;
  always_ff @(posedge mclk_i) begin
    past_hit <= reg_rd_i && hit;
  end

  // Reset is synchronous, so a release on an edge still shows reset values one cycle
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  // Read and write hits shared by several properties, and single-use mode conditions
  sequence s_read_hit;
    reg_rd_i && hit;
  endsequence
  sequence s_write_hit;
    reg_wr_i && hit;
  endsequence
  sequence s_global_on;
    !fields.no_power_switching && !fields.power_switch_mode && power_cmd_i.global_set;
  endsequence
  sequence s_global_off;
    !fields.no_power_switching && !fields.power_switch_mode && power_cmd_i.global_clear
      && !power_cmd_i.global_set;
  endsequence
  sequence s_oc_per_port;
    !rst_i && !fields.no_overcurrent_protection && fields.overcurrent_report_mode;
  endsequence

  a_dt_reads_zero: assert property (s_read_hit |=> reg_rvalid_o && !reg_rdata_o[DT_BIT])
    else $error("device type bit read as one");
  a_ndp_in_range: assert property (s_read_hit |=> reg_rdata_o[NDP_MSB:NDP_LSB] >= NDP_MIN
    && reg_rdata_o[NDP_MSB:NDP_LSB] <= NDP_MAX)
    else $error("port count out of range");
  a_rsvd_reads_zero: assert property (s_read_hit |=> reg_rdata_o[PGD_LSB-1:NO_OVERCURRENT_PROTECTION_BIT+1] == '0)
    else $error("reserved bits read as one");
  a_decode_miss: assert property (reg_rd_i && !hit |=> reg_rvalid_o && reg_rdata_o == RDATA_ZERO)
    else $error("unmapped read returned data");
  a_rdata_idle: assert property (!past_hit |-> reg_rdata_o == RDATA_ZERO)
    else $error("read data shown outside a mapped read");
  a_rvalid_pulse: assert property (reg_rd_i |=> reg_rvalid_o)
    else $error("read strobe gave no valid pulse");
  a_rvalid_idle: assert property (!reg_rd_i |=> !reg_rvalid_o)
    else $error("valid pulse without a read strobe");
  a_overcurrent_report_mode_reset: assert property (@(posedge mclk_i) $fell(rst_i) |->
    fields.overcurrent_report_mode == fields.power_switch_mode)
    else $error("report mode reset differs from switch mode");
  a_nps_powered: assert property (fields.no_power_switching |=> &port_power_o)
    else $error("unswitched ports not powered");
  a_global_on: assert property (s_global_on |=> &port_power_o)
    else $error("global set did not power every port");
  a_global_off: assert property (s_global_off |=> port_power_o == '0)
    else $error("global clear left a port powered");
  a_no_overcurrent_protection_silent: assert property (fields.no_overcurrent_protection |=> oc_report_o == '0)
    else $error("overcurrent reported without protection");
  a_oc_collective: assert property (!fields.no_overcurrent_protection && !fields.overcurrent_report_mode
    |=> oc_report_o == {RHDA_PORTS{$past(oc_global_i)}})
    else $error("collective overcurrent not spread to all ports");
  a_oc_per_port: assert property (s_oc_per_port |=> oc_report_o == $past(oc_port_i))
    else $error("per-port overcurrent not passed through");
  a_pgd_write: assert property (s_write_hit |=> fields.power_good_delay == $past(reg_wdata_i[PGD_MSB:PGD_LSB]))
    else $error("power good delay not written");
  a_mode_write: assert property (s_write_hit |=>
    fields.no_overcurrent_protection == $past(reg_wdata_i[NO_OVERCURRENT_PROTECTION_BIT])
    && fields.overcurrent_report_mode == $past(reg_wdata_i[OVERCURRENT_REPORT_MODE_BIT]))
    else $error("overcurrent fields not written");
  a_switch_write: assert property (s_write_hit |=>
    fields.no_power_switching == $past(reg_wdata_i[NPS_BIT])
    && fields.power_switch_mode == $past(reg_wdata_i[PSM_BIT]))
    else $error("power switching fields not written");
  a_fields_hold: assert property (!(reg_wr_i && hit) |=> $stable(fields))
    else $error("descriptor changed without a mapped write");

  for (genvar j = 0; j < RHDA_PORTS; j++) begin : g_chk
    a_masked_port: assert property (!fields.no_power_switching && fields.power_switch_mode
      && port_power_control_mask_i[j] && !power_cmd_i.port_set[j] && !power_cmd_i.port_clear[j]
      |=> $stable(port_power_o[j]))
      else $error("masked port moved without a port command");
    a_unmasked_port: assert property (!fields.no_power_switching && fields.power_switch_mode
      && !port_power_control_mask_i[j] && !power_cmd_i.global_set && !power_cmd_i.global_clear
      |=> $stable(port_power_o[j]))
      else $error("unmasked port moved without a global command");
    a_port_set: assert property (!fields.no_power_switching && fields.power_switch_mode
      && port_power_control_mask_i[j] && power_cmd_i.port_set[j] |=> port_power_o[j])
      else $error("masked port ignored a port set");
    a_port_clear: assert property (!fields.no_power_switching && fields.power_switch_mode
      && port_power_control_mask_i[j] && power_cmd_i.port_clear[j] && !power_cmd_i.port_set[j]
      |=> !port_power_o[j])
      else $error("masked port ignored a port clear");
    a_unmasked_on: assert property (!fields.no_power_switching && fields.power_switch_mode
      && !port_power_control_mask_i[j] && power_cmd_i.global_set |=> port_power_o[j])
      else $error("unmasked port ignored a global set");
    a_unmasked_off: assert property (!fields.no_power_switching && fields.power_switch_mode
      && !port_power_control_mask_i[j] && power_cmd_i.global_clear && !power_cmd_i.global_set
      |=> !port_power_o[j])
      else $error("unmasked port ignored a global clear");
  end

endmodule : rhda_regs

// [design/rhda_pkg.sv]
// Constants, field layout and carriers for the first root hub descriptor register.
// Assumes a single 25 MHz register clock and a synchronous active-high reset.
// Function
// - Bits 31-24 hold power-good delay, 2 ms units
// - Bit 12 set means no overcurrent protection
// - Report mode bit ignored while protection absent
// - Bit 11: 0 collective, 1 per-port reporting
// - Report mode resets equal to switch mode
// - Bit 10 compound device type reads zero
// - Bit 9: 0 switched, 1 always powered
// - Switch mode acts only when switching exists
// - Switch mode 0 powers all ports together
// - Masked port follows only per-port commands
// - Unmasked port follows only global commands
// - Bits 7-0 report port count, 1 to 15
// - Register decoded at offset 48h
package rhda_pkg;

  // Register map
  localparam logic [7:0]  RHDA_OFFSET          = 8'h48;
  localparam int          RHDA_ADDR_W          = 8;

  // Field positions
  localparam int          PGD_MSB              = 31;
  localparam int          PGD_LSB              = 24;
  localparam int          NO_OVERCURRENT_PROTECTION_BIT             = 12;
  localparam int          OVERCURRENT_REPORT_MODE_BIT             = 11;
  localparam int          DT_BIT               = 10;
  localparam int          NPS_BIT              = 9;
  localparam int          PSM_BIT              = 8;
  localparam int          NDP_MSB              = 7;
  localparam int          NDP_LSB              = 0;

  // Implementation values
  localparam int          RHDA_PORTS           = 2;
  localparam logic [7:0]  NDP_VALUE            = 8'h02;
  localparam logic [7:0]  NDP_MIN              = 8'h01;
  localparam logic [7:0]  NDP_MAX              = 8'h0F;
  localparam logic [7:0]  PGD_RESET            = 8'h01;
  localparam logic        NO_OVERCURRENT_PROTECTION_RESET           = 1'h0;
  localparam logic        NPS_RESET            = 1'h0;
  localparam logic        PSM_RESET            = 1'h1;
  localparam logic        OVERCURRENT_REPORT_MODE_RESET           = PSM_RESET;
  localparam logic        DT_VALUE             = 1'h0;
  localparam logic [31:0] RDATA_ZERO           = 32'h0000_0000;

  // Power-good timing
  localparam int          CLK_PERIOD_NS        = 40;
  localparam int          PGD_UNIT_NS          = 2000000;
  localparam int          PGD_UNIT_CYCLES      = PGD_UNIT_NS / CLK_PERIOD_NS;
  localparam int          PRE_W                = 24;

  // Writable descriptor fields
  typedef struct packed {
    logic [7:0] power_good_delay;
    logic       no_overcurrent_protection;
    logic       overcurrent_report_mode;
    logic       no_power_switching;
    logic       power_switch_mode;
  } rhda_fields_s;

  // Power commands from the root hub command decoder
  typedef struct packed {
    logic                  global_set;
    logic                  global_clear;
    logic [RHDA_PORTS-1:0] port_set;
    logic [RHDA_PORTS-1:0] port_clear;
  } rhda_power_cmd_s;

  // Power-good timer states
  typedef enum logic [1:0] {
    PG_OFF  = 2'b00,
    PG_WAIT = 2'b01,
    PG_GOOD = 2'b10
  } rhda_pg_e;

endpackage : rhda_pkg

// [design/rhda_pg_timer.sv]
// Per-port power-on to power-good timer.
// Assumes power_on_i is a registered level in the same clock domain.
`timescale 1ns/10ps
module rhda_pg_timer #(
  parameter int UNIT_CYCLES = rhda_pkg::PGD_UNIT_CYCLES
) (
  // Clock and reset
  input  wire logic       mclk_i,
  input  wire logic       rst_i,
  // Control
  input  wire logic       power_on_i,
  input  wire logic [7:0] delay_units_i,
  // Status
  output logic            good_o
);
  import rhda_pkg::*;

  localparam logic [PRE_W-1:0] PRE_LOAD = PRE_W'(UNIT_CYCLES - 1);

  rhda_pg_e         state;
  rhda_pg_e         next_state;
  logic [PRE_W-1:0] pre;
  logic [PRE_W-1:0] next_pre;
  logic [7:0]       units;
  logic [7:0]       next_units;
  logic             next_good;

  always_comb begin
    next_state = state;
    next_pre   = pre;
    next_units = units;
    case (state)
      PG_OFF: begin
        if (power_on_i) begin
          next_pre   = PRE_LOAD;
          next_units = delay_units_i;
          next_state = (delay_units_i == 8'h00) ? PG_GOOD : PG_WAIT;
        end
      end
      PG_WAIT: begin
        // Delay is latched at power-on so a rewrite cannot stretch a wait in progress
        if (!power_on_i) begin
          next_state = PG_OFF;
        end else if (pre == '0) begin
          if (units == 8'h01) begin
            next_state = PG_GOOD;
          end else begin
            next_units = units - 8'h01;
            next_pre   = PRE_LOAD;
          end
        end else begin
          next_pre = pre - PRE_W'(1);
        end
      end
      PG_GOOD: begin
        if (!power_on_i) begin
          next_state = PG_OFF;
        end
      end
      default: begin
        next_state = PG_OFF;
      end
    endcase
    next_good = (next_state == PG_GOOD);
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      state  <= PG_OFF;
      pre    <= '0;
      units  <= '0;
      good_o <= 1'b0;
    end else begin
      state  <= next_state;
      pre    <= next_pre;
      units  <= next_units;
      good_o <= next_good;
    end
  end

  // Checking helpers
  logic [31:0] wait_cnt;
  logic [7:0]  start_units;
  always_ff @(posedge mclk_i) begin
    if (rst_i || !power_on_i) begin
      wait_cnt <= '0;
    end else if (!good_o) begin
      wait_cnt <= wait_cnt + 32'h0000_0001;
    end
    if (rst_i) begin
      start_units <= '0;
    end else if (state == PG_OFF && power_on_i) begin
      start_units <= delay_units_i;
    end
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  a_pg_delay_len: assert property ($rose(good_o) |->
    wait_cnt == 32'(start_units) * 32'(UNIT_CYCLES) + 32'h0000_0001)
    else $error("power good did not follow the programmed delay");
  a_pg_drop_off: assert property (!power_on_i |=> !good_o)
    else $error("power good stayed with port power off");

endmodule : rhda_pg_timer

// [tb/rhda_host_model.sv]
// Host driver model: whole-word register writes and reads on the strobe port.
// Assumes it shares mclk_i with the register block and starts after reset.
`timescale 1ns/10ps
module rhda_host_model (
  // Clock
  input  wire logic        mclk_i,
  // Register port
  output logic [7:0]       reg_addr_o,
  output logic             reg_wr_o,
  output logic             reg_rd_o,
  output logic [31:0]      reg_wdata_o,
  input  wire logic [31:0] reg_rdata_i,
  input  wire logic        reg_rvalid_i
);
  localparam logic [31:0] RSVD_MASK = 32'h00FF_E000;

  initial begin
    reg_addr_o  = 8'h00;
    reg_wr_o    = 1'b0;
    reg_rd_o    = 1'b0;
    reg_wdata_o = 32'h0000_0000;
  end

  // Reserved bits carry their reset value of zero during the write strobe; the released data sets them to one
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    reg_addr_o  <= a;
    reg_wdata_o <= d & ~RSVD_MASK;
    reg_wr_o    <= 1'b1;
    @(posedge mclk_i);
    reg_wr_o    <= 1'b0;
    // Released lines do not keep the old value
    reg_addr_o  <= ~a;
    reg_wdata_o <= ~(d & ~RSVD_MASK);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic v);
    @(posedge mclk_i);
    reg_addr_o <= a;
    reg_rd_o   <= 1'b1;
    @(posedge mclk_i);
    reg_rd_o   <= 1'b0;
    reg_addr_o <= ~a;
    #1;
    d = reg_rdata_i;
    v = reg_rvalid_i;
  endtask : rd

  // Software cannot see power-good, so it simply sits out the programmed delay
  task automatic wait_good(input logic [7:0] units, input int unit_cycles);
    repeat (int'(units) * unit_cycles) @(posedge mclk_i);
    #1;
  endtask : wait_good
endmodule : rhda_host_model

// [tb/tb.sv]
// Self-checking bench for the first root hub descriptor register block.
// Assumes a shortened delay unit of 4 clocks; host model drives the register port.
`timescale 1ns/10ps
module tb;
  import rhda_pkg::*;
  localparam int UNIT = 4;
  logic                  mclk_i = 1'b0;
  logic                  rst_i  = 1'b1;
  logic [7:0]            reg_addr;
  logic                  reg_wr;
  logic                  reg_rd;
  logic [31:0]           reg_wdata;
  logic [31:0]           reg_rdata;
  logic                  reg_rvalid;
  logic [RHDA_PORTS-1:0] mask   = 2'h0;
  rhda_power_cmd_s       pcmd   = '0;
  logic [RHDA_PORTS-1:0] power;
  logic [RHDA_PORTS-1:0] good;
  logic                  oc_glb = 1'b0;
  logic [RHDA_PORTS-1:0] oc_prt = 2'h0;
  logic [RHDA_PORTS-1:0] oc_rep;
  int                    mismatches  = 0;
  int                    checks_done = 0;
  logic [31:0]           rdat;
  logic                  rv;
  typedef struct packed { logic [7:0] addr; logic [31:0] wdata; logic [31:0] exp; } rhda_row_s;
  rhda_row_s rows [5] = '{
    '{8'h48, 32'hAB00_1FFF, 32'hAB00_1B02},
    '{8'h48, 32'h0000_0000, 32'h0000_0002},
    '{8'h4C, 32'hFF00_1F00, 32'h0000_0002},
    '{8'h48, 32'h0500_0A00, 32'h0500_0A02},
    '{8'h48, 32'h0000_1500, 32'h0000_1102}};

  always #20 mclk_i = ~mclk_i;

  rhda_regs #(.UNIT_CYCLES(UNIT)) i_dut (
    .mclk_i(mclk_i), .rst_i(rst_i), .reg_addr_i(reg_addr), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
    .reg_wdata_i(reg_wdata), .reg_rdata_o(reg_rdata), .reg_rvalid_o(reg_rvalid),
    .port_power_control_mask_i(mask), .power_cmd_i(pcmd), .port_power_o(power),
    .port_power_good_o(good), .oc_global_i(oc_glb), .oc_port_i(oc_prt), .oc_report_o(oc_rep));

  rhda_host_model i_host (
    .mclk_i(mclk_i), .reg_addr_o(reg_addr), .reg_wr_o(reg_wr), .reg_rd_o(reg_rd),
    .reg_wdata_o(reg_wdata), .reg_rdata_i(reg_rdata), .reg_rvalid_i(reg_rvalid));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checks_done++;
    if (got !== exp) begin
      $display("unexpected at %0t: %s got %h want %h", $time, msg, got, exp);
      mismatches++;
    end
  endtask : chk

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string msg);
    i_host.rd(a, rdat, rv);
    chk({31'h0, rv}, 32'h1, "read valid");
    chk(rdat, exp, msg);
  endtask : rd_chk

  // One-cycle command pulse; returns just after the edge that takes it
  task automatic cmd(input logic gs, input logic gc, input logic [1:0] ps, input logic [1:0] pc);
    @(posedge mclk_i);
    pcmd <= '{gs, gc, ps, pc};
    @(posedge mclk_i);
    pcmd <= '0;
    #1;
  endtask : cmd

  task automatic wrap_up();
    $display("checks_done %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : wrap_up

  initial begin
    // The tests need under a hundred cycles; far beyond that means a hang
    repeat (2000) @(posedge mclk_i);
    mismatches++;
    wrap_up();
  end

  initial begin
    repeat (16) @(posedge mclk_i);
    rst_i <= 1'b0;
    #1;
    chk({26'h0, power, good, oc_rep}, 32'h0, "outputs in reset");
    rd_chk(8'h48, 32'h0100_0902, "reset value");
    rd_chk(8'h40, 32'h0, "unmapped read");
    foreach (rows[i]) begin
      i_host.wr(rows[i].addr, rows[i].wdata);
      rd_chk(8'h48, rows[i].exp, "table readback");
    end
    // Global switching with a delay of two units; the table rows left both ports powered
    i_host.wr(8'h48, 32'h0200_0000);
    cmd(1'b0, 1'b1, 2'h0, 2'h0);
    chk({30'h0, power}, 32'h0, "global clear before set");
    cmd(1'b1, 1'b0, 2'h0, 2'h0);
    chk({30'h0, power}, 32'h3, "global set");
    i_host.wait_good(8'h02, UNIT);
    chk({30'h0, good}, 32'h0, "good too early");
    @(posedge mclk_i);
    #1;
    chk({30'h0, good}, 32'h3, "good on time");
    cmd(1'b0, 1'b0, 2'h3, 2'h0);
    chk({30'h0, power}, 32'h3, "port cmd ignored in global mode");
    cmd(1'b0, 1'b1, 2'h0, 2'h0);
    chk({30'h0, power}, 32'h0, "global clear");
    // Per-port switching, port 0 masked
    i_host.wr(8'h48, 32'h0000_0100);
    mask <= 2'h1;
    cmd(1'b1, 1'b0, 2'h0, 2'h0);
    chk({30'h0, power}, 32'h2, "unmasked follows global");
    cmd(1'b0, 1'b0, 2'h3, 2'h0);
    chk({30'h0, power}, 32'h3, "masked follows port set");
    cmd(1'b0, 1'b1, 2'h0, 2'h0);
    chk({30'h0, power}, 32'h1, "masked ignores global clear");
    cmd(1'b0, 1'b0, 2'h0, 2'h3);
    chk({30'h0, power}, 32'h0, "port clear");
    // Always powered
    i_host.wr(8'h48, 32'h0000_0200);
    repeat (2) @(posedge mclk_i);
    #1;
    chk({30'h0, power}, 32'h3, "always powered");
    // Overcurrent reporting styles
    @(posedge mclk_i);
    oc_glb <= 1'b1;
    oc_prt <= 2'h1;
    i_host.wr(8'h48, 32'h0000_1800);
    repeat (2) @(posedge mclk_i);
    #1;
    chk({30'h0, oc_rep}, 32'h0, "no protection");
    i_host.wr(8'h48, 32'h0000_0000);
    repeat (2) @(posedge mclk_i);
    #1;
    chk({30'h0, oc_rep}, 32'h3, "collective report");
    i_host.wr(8'h48, 32'h0000_0800);
    repeat (2) @(posedge mclk_i);
    #1;
    chk({30'h0, oc_rep}, 32'h1, "per-port report");
    // Second reset restores the descriptor and drops every output
    @(posedge mclk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    rst_i <= 1'b0;
    #1;
    chk({26'h0, power, good, oc_rep}, 32'h0, "outputs after second reset");
    rd_chk(8'h48, 32'h0100_0902, "value after second reset");
    wrap_up();
  end
endmodule : tb
